// *** design/opcode_decoder.sv ***
`timescale 1ns/1ps
module opcode_decoder (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic clockEnable,
	input wire logic byteValid,
	input wire logic [7:0] byteData,
	output logic byteReady,
	input wire logic signFlag,
	input wire logic intrPending,
	output logic fetchEnable,
	output logic opValid,
	input wire logic opReady,
	output opdec_pkg::opKind_t opKind,
	output logic [7:0] opModrm,
	output logic [15:0] opFrameSize,
	output logic [7:0] opFrameLevel,
	output logic opWide,
	output logic opMoveTaken,
	output logic [5:0] opFlagsWritten,
	output logic [9:0] opCycles,
	output logic busy,
	output logic halted
);
	import opdec_pkg::*;

	typedef enum logic [3:0] {
		ST_FIRST, ST_ESCAPE, ST_MODRM, ST_SIZE_LO, ST_SIZE_HI, ST_LEVEL, ST_ISSUE, ST_EXEC, ST_HALTED
	} phase_t;

	typedef struct packed {
		phase_t phase;
		opKind_t kind;
		logic [7:0] second;
		logic [7:0] modrm;
		logic [15:0] size;
		logic [7:0] level;
		logic wide;
		logic taken;
		logic [5:0] flags;
		logic [9:0] cycles;
		logic [9:0] left;
	} state_t;

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic [1:0] rstSync_ff;
	logic rstSyncB;
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			rstSync_ff <= 2'h0;
		else
			rstSync_ff <= {rstSync_ff[0], 1'b1};
	end
	assign rstSyncB = rstSync_ff[1];

	state_t st_ff;
	state_t nxt_st;
	logic [9:0] countNow;

	// Clock count from the kind and level as they will stand at issue
	opdec_cycle_count cycleCount (
		.kind(nxt_st.kind),
		.level(nxt_st.level),
		.cycles(countNow)
	);

	// ----------------------------------------
	// Decode sequence
	// ----------------------------------------
	always_comb begin
		nxt_st = st_ff;
		byteReady = 1'b0;
		case (st_ff.phase)
			ST_FIRST: begin
				byteReady = 1'b1;
				if (byteValid) begin
					nxt_st.modrm = 8'h00;
					nxt_st.size = 16'h0000;
					nxt_st.level = 8'h00;
					nxt_st.wide = 1'b0;
					nxt_st.taken = 1'b0;
					nxt_st.flags = FLAGS_NONE;
					nxt_st.phase = ST_ISSUE;
					case (byteData)
						ESCAPE_BYTE: nxt_st.phase = ST_ESCAPE;
						OP_EXTEND_PAIR: nxt_st.kind = OPK_EXTEND_PAIR;
						OP_EXTEND_ACC: nxt_st.kind = OPK_EXTEND_ACC;
						OP_FIX_ADD: begin
							nxt_st.kind = OPK_FIX_ADD;
							nxt_st.flags = FLAGS_ZERO;
						end
						OP_FIX_SUB: begin
							nxt_st.kind = OPK_FIX_SUB;
							nxt_st.flags = FLAGS_ZERO;
						end
						OP_FRAME: begin
							nxt_st.kind = OPK_FRAME;
							nxt_st.phase = ST_SIZE_LO;
						end
						OP_HALT: nxt_st.kind = OPK_HALT;
						default: nxt_st.kind = OPK_UNKNOWN;
					endcase
				end
			end
			ST_ESCAPE: begin
				byteReady = 1'b1;
				if (byteValid) begin
					nxt_st.second = byteData;
					nxt_st.phase = ST_MODRM;
					if (byteData == OP_MOVE_NEG)
						nxt_st.kind = OPK_MOVE_NEG;
					else if (byteData == OP_MOVE_NONNEG)
						nxt_st.kind = OPK_MOVE_NONNEG;
					else if (byteData[7:1] == OP_COMPARE_EXCHANGE_HI) begin
						nxt_st.kind = OPK_COMPARE_EXCHANGE;
						nxt_st.wide = byteData[0];
						nxt_st.flags = FLAGS_ARITH;
					end else if (byteData == OP_GROUP_C7)
						nxt_st.kind = OPK_UNKNOWN;
					else begin
						nxt_st.phase = ST_ISSUE;
						if (byteData == OP_SPECIAL_READ)
							nxt_st.kind = OPK_SPECIAL_READ;
						else if (byteData == OP_SPECIAL_WRITE)
							nxt_st.kind = OPK_SPECIAL_WRITE;
						else
							nxt_st.kind = OPK_UNKNOWN;
					end
				end
			end
			ST_MODRM: begin
				byteReady = 1'b1;
				if (byteValid) begin
					nxt_st.modrm = byteData;
					nxt_st.phase = ST_ISSUE;
					// Sign flag sampled with the modrm byte, before the move is issued
					if (st_ff.kind == OPK_MOVE_NEG)
						nxt_st.taken = signFlag;
					else if (st_ff.kind == OPK_MOVE_NONNEG)
						nxt_st.taken = !signFlag;
					if (st_ff.second == OP_GROUP_C7 && byteData[5:3] == REG_EIGHT_BYTES) begin
						nxt_st.kind = OPK_EIGHT_BYTES;
						nxt_st.flags = FLAGS_NONE;
					end
				end
			end
			ST_SIZE_LO: begin
				byteReady = 1'b1;
				if (byteValid) begin
					nxt_st.size[7:0] = byteData;
					nxt_st.phase = ST_SIZE_HI;
				end
			end
			ST_SIZE_HI: begin
				byteReady = 1'b1;
				if (byteValid) begin
					nxt_st.size[15:8] = byteData;
					nxt_st.phase = ST_LEVEL;
				end
			end
			ST_LEVEL: begin
				byteReady = 1'b1;
				if (byteValid) begin
					nxt_st.level = byteData;
					nxt_st.phase = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				// Hold the decoded operation until the pipeline accepts it
				if (opReady) begin
					nxt_st.left = st_ff.cycles;
					nxt_st.phase = ST_EXEC;
				end
			end
			ST_EXEC: begin
				// Busy for the documented clock count before the next fetch
				if (st_ff.left <= 10'h001)
					nxt_st.phase = (st_ff.kind == OPK_HALT) ? ST_HALTED : ST_FIRST;
				else
					nxt_st.left = st_ff.left - 10'h001;
			end
			ST_HALTED: begin
				if (intrPending)
					nxt_st.phase = ST_FIRST;
			end
			default: nxt_st.phase = ST_FIRST;
		endcase
		if (nxt_st.phase == ST_ISSUE && st_ff.phase != ST_ISSUE)
			nxt_st.cycles = countNow;
		if (!clockEnable)
			byteReady = 1'b0;
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstSyncB) begin
		if (!rstSyncB) begin
			st_ff <= '{phase: ST_FIRST, kind: OPK_NONE, default: '0};
		end else if (clockEnable) begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign opValid = (st_ff.phase == ST_ISSUE) && clockEnable;
	assign opKind = st_ff.kind;
	assign opModrm = st_ff.modrm;
	assign opFrameSize = st_ff.size;
	assign opFrameLevel = st_ff.level;
	assign opWide = st_ff.wide;
	assign opMoveTaken = st_ff.taken;
	assign opFlagsWritten = st_ff.flags;
	assign opCycles = st_ff.cycles;
	assign busy = (st_ff.phase == ST_EXEC);
	assign halted = (st_ff.phase == ST_HALTED);
	assign fetchEnable = (st_ff.phase != ST_HALTED);
endmodule

// *** design/opdec_pkg.sv ***
package opdec_pkg;
	// ----------------------------------------
	// Opcode bytes
	// ----------------------------------------
	localparam logic [7:0] ESCAPE_BYTE = 8'h0F;
	localparam logic [7:0] OP_MOVE_NEG = 8'h48;
	localparam logic [7:0] OP_MOVE_NONNEG = 8'h49;
	localparam logic [6:0] OP_COMPARE_EXCHANGE_HI = 7'h58;
	localparam logic [7:0] OP_GROUP_C7 = 8'hC7;
	localparam logic [2:0] REG_EIGHT_BYTES = 3'h1;
	localparam logic [7:0] OP_SPECIAL_READ = 8'h3C;
	localparam logic [7:0] OP_SPECIAL_WRITE = 8'h3D;
	localparam logic [7:0] OP_EXTEND_PAIR = 8'h99;
	localparam logic [7:0] OP_EXTEND_ACC = 8'h98;
	localparam logic [7:0] OP_FIX_ADD = 8'h27;
	localparam logic [7:0] OP_FIX_SUB = 8'h2F;
	localparam logic [7:0] OP_FRAME = 8'hC8;
	localparam logic [7:0] OP_HALT = 8'hF4;

	// ----------------------------------------
	// Clock counts
	// ----------------------------------------
	localparam logic [9:0] CYC_MOVE = 10'h001;
	localparam logic [9:0] CYC_COMPARE_EXCHANGE = 10'h006;
	localparam logic [9:0] CYC_EIGHT_BYTES = 10'h001;
	localparam logic [9:0] CYC_SPECIAL = 10'h001;
	localparam logic [9:0] CYC_EXTEND_PAIR = 10'h002;
	localparam logic [9:0] CYC_EXTEND_ACC = 10'h003;
	localparam logic [9:0] CYC_FIX = 10'h002;
	localparam logic [9:0] CYC_FRAME_L0 = 10'h00D;
	localparam logic [9:0] CYC_FRAME_BASE = 10'h011;
	localparam logic [9:0] CYC_HALT = 10'h00A;
	localparam logic [9:0] CYC_UNKNOWN = 10'h001;

	// ----------------------------------------
	// Operation codes and flag masks (O S Z A P C)
	// ----------------------------------------
	typedef enum logic [3:0] {
		OPK_NONE, OPK_MOVE_NEG, OPK_MOVE_NONNEG, OPK_COMPARE_EXCHANGE, OPK_EIGHT_BYTES,
		OPK_SPECIAL_READ, OPK_SPECIAL_WRITE, OPK_EXTEND_PAIR, OPK_EXTEND_ACC,
		OPK_FIX_ADD, OPK_FIX_SUB, OPK_FRAME, OPK_HALT, OPK_UNKNOWN
	} opKind_t;
	localparam logic [5:0] FLAGS_NONE = 6'h00;
	localparam logic [5:0] FLAGS_ARITH = 6'h3F;
	localparam logic [5:0] FLAGS_ZERO = 6'h08;
endpackage

// *** design/opdec_cycle_count.sv ***
`timescale 1ns/1ps
module opdec_cycle_count (
	input opdec_pkg::opKind_t kind,
	input wire logic [7:0] level,
	output logic [9:0] cycles
);
	import opdec_pkg::*;
	// ----------------------------------------
	// Clock count per decoded operation
	// ----------------------------------------
	always_comb begin
		case (kind)
			OPK_MOVE_NEG, OPK_MOVE_NONNEG: cycles = CYC_MOVE;
			OPK_COMPARE_EXCHANGE: cycles = CYC_COMPARE_EXCHANGE;
			OPK_EIGHT_BYTES: cycles = CYC_EIGHT_BYTES;
			OPK_SPECIAL_READ, OPK_SPECIAL_WRITE: cycles = CYC_SPECIAL;
			OPK_EXTEND_PAIR: cycles = CYC_EXTEND_PAIR;
			OPK_EXTEND_ACC: cycles = CYC_EXTEND_ACC;
			OPK_FIX_ADD, OPK_FIX_SUB: cycles = CYC_FIX;
			OPK_FRAME: begin
				// Level one shares the base figure; above it two clocks per level
				if (level == 8'h00)
					cycles = CYC_FRAME_L0;
				else if (level == 8'h01)
					cycles = CYC_FRAME_BASE;
				else
					cycles = CYC_FRAME_BASE + {1'b0, level, 1'b0};
			end
			OPK_HALT: cycles = CYC_HALT;
			default: cycles = CYC_UNKNOWN;
		endcase
	end
endmodule

// *** verification/opcode_decoder_monitor.sv ***
`timescale 1ns/1ps
module opcode_decoder_monitor (
	input logic clock,
	input logic rst_b,
	input logic byteReady,
	input logic fetchEnable,
	input logic opValid,
	input logic opReady,
	input opdec_pkg::opKind_t opKind,
	input logic [7:0] opFrameLevel,
	input logic [5:0] opFlagsWritten,
	input logic [9:0] opCycles,
	input logic busy,
	input logic halted
);
	import opdec_pkg::*;
	// ----------------
	// Decode checks
	// ----------------
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	logic [9:0] frameCost;
	// Deep frames cost two clocks per level
	assign frameCost = (opFrameLevel < 8'h02) ? (opFrameLevel[0] ? 10'h011 : 10'h00D) : 10'h011 + {1'b0, opFrameLevel, 1'b0};
	chk_move_cost: assert property (opValid && opKind inside {OPK_MOVE_NEG, OPK_MOVE_NONNEG}
		|-> opCycles == 10'h001 && opFlagsWritten == 6'h00) else $error("bad move cost");
	chk_swap_cost: assert property (opValid && opKind == OPK_COMPARE_EXCHANGE
		|-> opCycles == 10'h006 && opFlagsWritten == 6'h3F) else $error("bad swap cost");
	chk_eight_flags: assert property (opValid && opKind == OPK_EIGHT_BYTES
		|-> opFlagsWritten == 6'h00) else $error("bad eight flags");
	chk_special_cost: assert property (opValid && opKind inside {OPK_SPECIAL_READ, OPK_SPECIAL_WRITE}
		|-> opCycles == 10'h001) else $error("bad special cost");
	chk_pair_busy: assert property (opValid && opReady && opKind == OPK_EXTEND_PAIR
		|=> busy [*2] ##1 !busy) else $error("bad pair busy");
	chk_acc_cost: assert property (opValid && opKind == OPK_EXTEND_ACC
		|-> opCycles == 10'h003 && opFlagsWritten == 6'h00) else $error("bad extend cost");
	chk_fix_flags: assert property (opValid && opKind inside {OPK_FIX_ADD, OPK_FIX_SUB}
		|-> opCycles == 10'h002 && opFlagsWritten == 6'h08) else $error("bad fix cost");
	chk_frame_cost: assert property (opValid && opKind == OPK_FRAME
		|-> opCycles == frameCost && opFlagsWritten == 6'h00) else $error("bad frame cost");
	chk_halt_idle: assert property (halted
		|-> !fetchEnable && !byteReady) else $error("halt not idle");
	cover property (halted);
	cover property (opValid && !opReady);
	cover property (opValid && opKind == OPK_FRAME);
endmodule
bind opcode_decoder opcode_decoder_monitor u_mon (.clock(clock), .rst_b(rst_b), .byteReady(byteReady),
	.fetchEnable(fetchEnable), .opValid(opValid), .opReady(opReady), .opKind(opKind), .opFrameLevel(opFrameLevel),
	.opFlagsWritten(opFlagsWritten), .opCycles(opCycles), .busy(busy), .halted(halted));

// *** verification/opcode_decoder_tb_top.sv ***
`timescale 1ns/1ps
module opcode_decoder_tb_top;
	import opdec_pkg::*;
	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic byteValid = 1'b0;
	logic [7:0] byteData = 8'h00;
	logic signFlag = 1'b0;
	logic intrPending = 1'b0;
	logic opReady = 1'b1;
	logic clockEnable = 1'b1;
	logic byteReady, fetchEnable, opValid, opWide, opMoveTaken, busy, halted;
	opKind_t opKind;
	logic [7:0] opModrm, opFrameLevel;
	logic [15:0] opFrameSize;
	logic [5:0] opFlagsWritten;
	logic [9:0] opCycles;
	int err_total = 0;
	int checked = 0;
	opcode_decoder dut (.clock(clock), .rst_b(rst_b), .clockEnable(clockEnable), .byteValid(byteValid),
		.byteData(byteData), .byteReady(byteReady), .signFlag(signFlag), .intrPending(intrPending),
		.fetchEnable(fetchEnable), .opValid(opValid), .opReady(opReady), .opKind(opKind), .opModrm(opModrm),
		.opFrameSize(opFrameSize), .opFrameLevel(opFrameLevel), .opWide(opWide), .opMoveTaken(opMoveTaken),
		.opFlagsWritten(opFlagsWritten), .opCycles(opCycles), .busy(busy), .halted(halted));
	// 200 MHz core clock
	initial forever #2.5 clock = ~clock;
	// ----------------
	// Helpers
	// ----------------
	task automatic report_and_stop();
		if (err_total == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Bounded wait, so a dead handshake ends the run
	task automatic wait_hi(ref logic s);
		int w;
		w = 0;
		@(negedge clock);
		while (s !== 1'b1) begin
			w++;
			if (w > 600) begin
				chk(16'(s), 16'h0001);
				report_and_stop();
			end
			@(negedge clock);
		end
	endtask
	// Feeds n bytes, optionally stalls issue, then counts busy clocks
	task automatic op(input int n, input logic [31:0] bs, input logic st, input opKind_t k, input logic [9:0] cyc,
		input logic [5:0] fl);
		int c;
		opReady <= !st;
		for (int i = 0; i < n; i++) begin
			byteValid <= 1'b1;
			byteData <= bs[31 - 8 * i -: 8];
			wait_hi(byteReady);
			@(posedge clock);
		end
		byteValid <= 1'b0;
		wait_hi(opValid);
		chk(16'(opKind), 16'(k));
		chk(16'(opCycles), 16'(cyc));
		chk(16'(opFlagsWritten), 16'(fl));
		if (st) begin
			repeat (3) @(negedge clock);
			chk(16'(opValid), 16'h0001);
			@(posedge clock);
			opReady <= 1'b1;
		end
		@(posedge clock);
		c = 0;
		@(negedge clock);
		while (busy === 1'b1 && c < 600) begin
			c++;
			@(negedge clock);
		end
		chk(16'(c), 16'(cyc));
		@(posedge clock);
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_moves();
		signFlag <= 1'b1;
		op(3, 32'h0F48C100, 1'b0, OPK_MOVE_NEG, 10'h001, 6'h00);
		chk(16'(opMoveTaken), 16'h0001);
		op(3, 32'h0F49C100, 1'b0, OPK_MOVE_NONNEG, 10'h001, 6'h00);
		chk(16'({opMoveTaken, opModrm}), 16'h00C1);
	endtask
	task automatic t_swap();
		op(3, 32'h0FB1C800, 1'b0, OPK_COMPARE_EXCHANGE, 10'h006, 6'h3F);
		chk(16'(opWide), 16'h0001);
		op(3, 32'h0FB00600, 1'b0, OPK_COMPARE_EXCHANGE, 10'h006, 6'h3F);
		chk(16'(opWide), 16'h0000);
		op(3, 32'h0FC70E00, 1'b0, OPK_EIGHT_BYTES, 10'h001, 6'h00);
		op(3, 32'h0FC71600, 1'b0, OPK_UNKNOWN, 10'h001, 6'h00);
	endtask
	task automatic t_short();
		op(2, 32'h0F3C0000, 1'b0, OPK_SPECIAL_READ, 10'h001, 6'h00);
		op(2, 32'h0F3D0000, 1'b0, OPK_SPECIAL_WRITE, 10'h001, 6'h00);
		op(1, 32'h99000000, 1'b1, OPK_EXTEND_PAIR, 10'h002, 6'h00);
		op(1, 32'h98000000, 1'b0, OPK_EXTEND_ACC, 10'h003, 6'h00);
		op(1, 32'h27000000, 1'b0, OPK_FIX_ADD, 10'h002, 6'h08);
		op(1, 32'h2F000000, 1'b0, OPK_FIX_SUB, 10'h002, 6'h08);
		op(2, 32'h0FA20000, 1'b0, OPK_UNKNOWN, 10'h001, 6'h00);
		op(1, 32'hF5000000, 1'b0, OPK_UNKNOWN, 10'h001, 6'h00);
	endtask
	task automatic t_frame();
		int lv[4] = '{32'h0, 32'h1, 32'h2, 32'hFF};
		int e;
		foreach (lv[i]) begin
			e = (lv[i] == 32'h0) ? 32'hD : (lv[i] == 32'h1) ? 32'h11 : 32'h11 + 32'h2 * lv[i];
			op(4, {24'hC83412, 8'(lv[i])}, 1'b0, OPK_FRAME, 10'(e), 6'h00);
			chk(opFrameSize, 16'h1234);
			chk(16'(opFrameLevel), 16'(lv[i]));
		end
	endtask
	// Byte offered while frozen must not be taken
	task automatic t_freeze();
		clockEnable <= 1'b0;
		byteValid <= 1'b1;
		byteData <= OP_EXTEND_ACC;
		repeat (3) @(negedge clock);
		chk(16'({byteReady, opValid, busy}), 16'h0000);
		@(posedge clock);
		byteValid <= 1'b0;
		clockEnable <= 1'b1;
		@(negedge clock);
		chk(16'({byteReady, opValid, busy}), 16'h0004);
		@(posedge clock);
	endtask
	task automatic t_halt();
		op(1, 32'hF4000000, 1'b0, OPK_HALT, 10'h00A, 6'h00);
		repeat (5) @(negedge clock);
		chk(16'({halted, fetchEnable, byteReady}), 16'h0004);
		@(posedge clock);
		intrPending <= 1'b1;
		wait_hi(fetchEnable);
		chk(16'(halted), 16'h0000);
		@(posedge clock);
		intrPending <= 1'b0;
		// Second halt left by a mid-run reset instead
		op(1, 32'hF4000000, 1'b0, OPK_HALT, 10'h00A, 6'h00);
		rst_b <= 1'b0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		chk(16'({halted, fetchEnable, byteReady}), 16'h0003);
		chk(16'(opKind), 16'(OPK_NONE));
		@(posedge clock);
	endtask
	// Reset held ten clocks, first byte after the synchroniser settles
	initial begin
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		repeat (3) @(posedge clock);
		t_moves();
		t_swap();
		t_short();
		t_frame();
		t_freeze();
		t_halt();
		report_and_stop();
	end
endmodule
